// ---- bench/flash_host_pin_chk.sv ----
// Purpose: Port-level checks for the flash host pin front end.
// Assumes: Pins pass a two-flop synchroniser before use.
// Notes: Bound to the top module below the checker.
`timescale 1ns/1ps
`default_nettype none
module flash_host_pin_chk
   import flash_pins_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_frame_n,
   input wire logic i_interface_reset_n,
   input wire logic i_cpu_reset_n,
   input wire logic i_top_lock_n,
   input wire logic i_main_lock_n,
   input wire logic i_read_enable_n,
   input wire logic i_pe_busy,
   input wire logic [NUM_BLOCKS-1:0] i_lock_reg,
   input wire logic [3:0] o_lad,
   input wire logic o_lad_oe_n,
   input wire logic o_byte_lines_oe_n,
   input wire logic o_ready_busy_n,
   input wire logic o_ready_busy_oe_n,
   input wire core_req_t o_core_req,
   input wire logic [NUM_BLOCKS-1:0] o_block_protect,
   input wire logic o_cmd_reset,
   input wire logic o_mux_mode
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_quiet;
      o_cmd_reset ##1 o_cmd_reset |-> o_lad_oe_n && o_byte_lines_oe_n && o_ready_busy_oe_n
         && !o_core_req.valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output driven in reset");
   property p_pin_rst;
      (!i_cpu_reset_n || !i_interface_reset_n) |-> ##[1:3] o_cmd_reset;
   endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");
   property p_rb;
      o_ready_busy_n == !i_pe_busy;
   endproperty
   a_rb: assert property (p_rb) else $error("ready busy wrong");
   property p_top;
      o_block_protect[7] == (i_lock_reg[7] || !$past(i_top_lock_n, 2));
   endproperty
   a_top: assert property (p_top) else $error("top protect wrong");
   property p_main;
      o_block_protect[6:0] == (i_lock_reg[6:0] | {7{!$past(i_main_lock_n, 2)}});
   endproperty
   a_main: assert property (p_main) else $error("main protect wrong");
   property p_hold;
      !o_cmd_reset && !$past(o_cmd_reset) && !$past(o_cmd_reset, 2) |-> $stable(o_mux_mode);
   endproperty
   a_hold: assert property (p_hold) else $error("port choice changed");
   property p_port;
      !o_cmd_reset |-> (o_mux_mode ? o_lad_oe_n : (o_ready_busy_oe_n && o_byte_lines_oe_n));
   endproperty
   a_port: assert property (p_port) else $error("wrong port active");
   property p_abort;
      !o_lad_oe_n && !$past(i_frame_n, 2) |-> ##[1:2] o_lad_oe_n;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not released");
   property p_sync;
      $fell(o_lad_oe_n) |-> o_lad == SYNC_READY;
   endproperty
   a_sync: assert property (p_sync) else $error("first nibble not sync");
   property p_pulse;
      o_core_req.valid |=> !o_core_req.valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("request not a pulse");
   property p_rd_oe;
      !o_byte_lines_oe_n |-> o_mux_mode && !$past(i_read_enable_n, 3);
   endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("byte lines driven wrongly");
   c_abort: cover property (!o_lad_oe_n && !$past(i_frame_n, 2));
   c_prog_rd: cover property ($fell(o_byte_lines_oe_n));
   c_write: cover property (o_core_req.valid && o_core_req.we);
endmodule
bind flash_host_pin_control flash_host_pin_chk chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_frame_n(i_frame_n), .i_interface_reset_n(i_interface_reset_n),
   .i_cpu_reset_n(i_cpu_reset_n), .i_top_lock_n(i_top_lock_n), .i_main_lock_n(i_main_lock_n),
   .i_read_enable_n(i_read_enable_n), .i_pe_busy(i_pe_busy), .i_lock_reg(i_lock_reg),
   .o_lad(o_lad), .o_lad_oe_n(o_lad_oe_n), .o_byte_lines_oe_n(o_byte_lines_oe_n),
   .o_ready_busy_n(o_ready_busy_n), .o_ready_busy_oe_n(o_ready_busy_oe_n),
   .o_core_req(o_core_req), .o_block_protect(o_block_protect), .o_cmd_reset(o_cmd_reset),
   .o_mux_mode(o_mux_mode));
`default_nettype wire

// ---- bench/flash_host_pin_control_tb.sv ----
// Purpose: Self-checking bench for the flash host pin front end.
// Assumes: A one-cycle array core model answers reads.
// Notes: Straps end on a non-boot setting to exercise the compare.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module flash_host_pin_control_tb;
   import flash_pins_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rp_n = 1'b1, cpu_n = 1'b1, isel = 1'b0, busy = 1'b0;
   logic top_n = 1'b1, main_n = 1'b1, rc = 1'b1, g_n = 1'b1, w_n = 1'b1;
   logic [2:0] strap = 3'h0;
   logic [4:0] aux = 5'h00;
   logic [10:0] maddr = 11'h000;
   logic [7:0] dq_in = 8'h00, rdata = 8'h00, lock_reg = 8'h00, dq_out, prot, rd;
   logic [3:0] dut_lad, host_lad, lad_bus;
   logic lad_oe_n, dq_oe_n, rb_n, rb_oe_n, cmd_rst, mux_mode, frame_n, hit;
   logic [18:0] a;
   logic [31:0] wa;
   core_req_t req, last_req;
   int miscompares = 0, samples_checked = 0, req_cnt = 0, k, n;
   always #20 clk = ~clk;
   assign lad_bus = lad_oe_n ? host_lad : dut_lad;
   function automatic logic [7:0] pat(input logic [18:0] x);
      return x[7:0] ^ x[18:11];
   endfunction
   function automatic logic [31:0] adr(input logic m, input logic [2:0] id, input logic [18:0] lo);
      return {9'h000, m, id, lo};
   endfunction
   always @(posedge clk) begin
      if (req.valid) begin
         last_req <= req;
         req_cnt <= req_cnt + 1;
         if (!req.we) rdata <= pat(req.addr);
      end
   end
   lpc_host_model host (.i_clk(clk), .i_lad(lad_bus), .i_drv_n(lad_oe_n), .o_frame_n(frame_n),
      .o_lad(host_lad));
   flash_host_pin_control dut (.i_clk(clk), .i_sys_rst(rst), .i_frame_n(frame_n),
      .i_lad(lad_bus), .o_lad(dut_lad), .o_lad_oe_n(lad_oe_n), .i_chip_select_strap(strap),
      .i_aux_inputs(aux), .i_interface_select(isel), .i_interface_reset_n(rp_n),
      .i_cpu_reset_n(cpu_n), .i_top_lock_n(top_n), .i_main_lock_n(main_n),
      .i_mux_addr_lines(maddr), .i_row_col_select(rc), .i_read_enable_n(g_n),
      .i_write_strobe_n(w_n), .i_byte_lines(dq_oe_n ? dq_in : dq_out), .o_byte_lines(dq_out),
      .o_byte_lines_oe_n(dq_oe_n), .o_ready_busy_n(rb_n), .o_ready_busy_oe_n(rb_oe_n),
      .o_core_req(req), .i_core_rdata(rdata), .i_pe_busy(busy), .i_lock_reg(lock_reg),
      .o_block_protect(prot), .o_cmd_reset(cmd_rst), .o_mux_mode(mux_mode));
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic lpc_chk(input logic we, input logic [31:0] ad, input logic [7:0] wd,
      input logic eh, input logic [7:0] er);
      host.xfer(we, ad, wd, 1'b0, rd, hit);
      if (!we) `CHK({hit, rd}, {eh, er})
   endtask
   initial begin
      repeat (3) @(posedge clk);
      `CHK({lad_oe_n, dq_oe_n, rb_oe_n, cmd_rst}, 4'hf)
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK({mux_mode, cmd_rst}, 2'b00)
      for (k = 0; k < 8; k += 3) begin
         strap <= k[2:0];
         a = 19'h12345 + k[18:0];
         repeat (3) @(posedge clk);
         lpc_chk(1'b0, adr(1'b1, ~k[2:0], a), 8'h00, 1'b1, pat(a));
         `CHK(last_req.addr, a)
         n = req_cnt;
         lpc_chk(1'b0, adr(1'b1, k[2:0] ^ 3'h2, a), 8'h00, 1'b0, 8'h00);
         `CHK(req_cnt, n)
      end
      aux <= 5'h15;
      repeat (3) @(posedge clk);
      lpc_chk(1'b0, adr(1'b0, ~strap, 19'h0), 8'h00, 1'b1, 8'h15);
      lpc_chk(1'b1, adr(1'b1, ~strap, 19'h70001), 8'h40, 1'b0, 8'h00);
      `CHK({last_req.we, last_req.addr, last_req.wdata}, {1'b1, 19'h70001, 8'h40})
      busy <= 1'b1;
      n = req_cnt;
      @(posedge clk);
      `CHK(rb_n, 1'b0)
      lpc_chk(1'b1, adr(1'b1, ~strap, 19'h10), 8'h20, 1'b0, 8'h00);
      `CHK(req_cnt, n)
      lpc_chk(1'b1, adr(1'b1, ~strap, 19'h10), SUSPEND_CMD, 1'b0, 8'h00);
      `CHK(req_cnt, n + 1)
      busy <= 1'b0;
      // Byte at 19'h5 is 8'h05; the aborted read keeps the low nibble only.
      host.xfer(1'b0, adr(1'b1, ~strap, 19'h5), 8'h00, 1'b1, rd, hit);
      `CHK({hit, lad_oe_n, rd}, {2'b11, 8'hf5})
      n = req_cnt;
      // A matching address follows the abort; it must not be taken as the rest of a frame.
      wa = adr(1'b1, ~strap, 19'h33);
      host.nib(1'b0, LPC_START);
      host.nib(1'b1, 4'h4);
      host.nib(1'b0, TAR_IDLE);
      for (k = 6; k >= 0; k--) host.nib(1'b1, wa[k*4+:4]);
      host.nib(1'b1, TAR_IDLE);
      repeat (16) @(posedge clk);
      `CHK(req_cnt, n)
      lpc_chk(1'b0, adr(1'b1, ~strap, 19'h33), 8'h00, 1'b1, pat(19'h33));
      lock_reg <= 8'h21;
      for (k = 0; k < 4; k++) begin
         {top_n, main_n} <= k[1:0];
         repeat (4) @(posedge clk);
         `CHK(prot, 8'h21 | {!k[1], {7{!k[0]}}})
      end
      cpu_n <= 1'b0;
      isel <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK({cmd_rst, lad_oe_n}, 2'b11)
      cpu_n <= 1'b1;
      repeat (5) @(posedge clk);
      isel <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK({mux_mode, rb_oe_n, cmd_rst}, 3'b100)
      maddr <= 11'h5a3;
      rc <= 1'b0;
      repeat (4) @(posedge clk);
      maddr <= 11'h0c7;
      rc <= 1'b1;
      repeat (4) @(posedge clk);
      g_n <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK({dq_oe_n, last_req.addr}, {1'b0, 8'hc7, 11'h5a3})
      `CHK(dq_out, pat({8'hc7, 11'h5a3}))
      g_n <= 1'b1;
      dq_in <= 8'h70;
      w_n <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(dq_oe_n, 1'b1)
      w_n <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK({last_req.we, last_req.wdata}, {1'b1, 8'h70})
      rp_n <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK({cmd_rst, dq_oe_n, rb_oe_n}, 3'b111)
      rp_n <= 1'b1;
      repeat (5) @(posedge clk);
      lpc_chk(1'b0, adr(1'b1, ~strap, 19'h44), 8'h00, 1'b1, pat(19'h44));
      test_done;
   end
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
endmodule
`default_nettype wire

// ---- bench/lpc_host_model.sv ----
// Purpose: Behavioural LPC host that frames reads and writes.
// Assumes: The bus is pulled up, so released lines read all ones.
// Notes: Changes its pins only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model
   import flash_pins_pkg::*;
(
   input wire logic i_clk,
   input wire logic [3:0] i_lad,
   input wire logic i_drv_n,
   output logic o_frame_n,
   output logic [3:0] o_lad
);
   initial begin
      o_frame_n = 1'b1;
      o_lad = 4'hf;
   end
   task automatic nib(input logic f, input logic [3:0] v);
      @(posedge i_clk);
      o_frame_n <= f;
      o_lad <= v;
   endtask
   task automatic xfer(input logic we, input logic [31:0] a, input logic [7:0] wd,
      input logic brk, output logic [7:0] rd, output logic hit);
      int n;
      nib(1'b0, LPC_START);
      nib(1'b1, {CYC_MEMORY, we, 1'b0});
      for (n = 7; n >= 0; n--) nib(1'b1, a[n*4+:4]);
      if (we) begin
         nib(1'b1, wd[3:0]);
         nib(1'b1, wd[7:4]);
      end
      nib(1'b1, TAR_IDLE);
      nib(1'b1, TAR_IDLE);
      // The abort is timed to reach the device while the low data nibble is out,
      // so the high nibble must read as the released bus.
      if (brk) begin
         nib(1'b1, TAR_IDLE);
         nib(1'b0, TAR_IDLE);
         nib(1'b1, TAR_IDLE);
      end
      hit = 1'b0;
      rd = 8'h00;
      for (n = 0; n < 12 && !hit; n++) begin
         @(posedge i_clk);
         hit = !i_drv_n;
      end
      if (hit) begin
         @(posedge i_clk);
         rd[3:0] = i_lad;
         @(posedge i_clk);
         rd[7:4] = i_lad;
      end
      repeat (4) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ---- hw/flash_host_pin_control.sv ----
// Purpose: Pin-level front end of a boot flash, LPC and multiplexed programmer ports.
// Assumes: Every pin is synchronised before use; core answers reads one cycle after a request.
// Notes: Output enables are active low; high means the pin is released.
`timescale 1ns/1ps
`default_nettype none
module flash_host_pin_control
   import flash_pins_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_frame_n,
   input wire logic [3:0] i_lad,
   output logic [3:0] o_lad,
   output logic o_lad_oe_n,
   input wire logic [2:0] i_chip_select_strap,
   input wire logic [4:0] i_aux_inputs,
   input wire logic i_interface_select,
   input wire logic i_interface_reset_n,
   input wire logic i_cpu_reset_n,
   input wire logic i_top_lock_n,
   input wire logic i_main_lock_n,
   input wire logic [10:0] i_mux_addr_lines,
   input wire logic i_row_col_select,
   input wire logic i_read_enable_n,
   input wire logic i_write_strobe_n,
   input wire logic [7:0] i_byte_lines,
   output logic [7:0] o_byte_lines,
   output logic o_byte_lines_oe_n,
   output logic o_ready_busy_n,
   output logic o_ready_busy_oe_n,
   output core_req_t o_core_req,
   input wire logic [7:0] i_core_rdata,
   input wire logic i_pe_busy,
   input wire logic [NUM_BLOCKS-1:0] i_lock_reg,
   output logic [NUM_BLOCKS-1:0] o_block_protect,
   output logic o_cmd_reset,
   output logic o_mux_mode
);
   // Only suspend may reach the command interface while the controller runs.
   function automatic logic write_allowed(input logic [7:0] data, input logic busy);
      write_allowed = !busy || (data == SUSPEND_CMD);
   endfunction

   pins_t pins_raw;
   pins_t pins;
   logic [PIN_W-1:0] pins_vec;

   assign pins_raw = '{frame_n: i_frame_n, lad: i_lad,
      chip_select_strap: i_chip_select_strap, aux_inputs: i_aux_inputs,
      interface_select: i_interface_select, interface_reset_n: i_interface_reset_n,
      cpu_reset_n: i_cpu_reset_n, top_lock_n: i_top_lock_n, main_lock_n: i_main_lock_n,
      mux_addr_lines: i_mux_addr_lines, row_col_select: i_row_col_select,
      read_enable_n: i_read_enable_n, write_strobe_n: i_write_strobe_n,
      byte_lines: i_byte_lines};

   pin_sync #(.W(PIN_W)) u_sync (
      .i_clk(i_clk),
      .i_async(pins_raw),
      .o_sync(pins_vec)
   );
   assign pins = pins_t'(pins_vec);

   // Internal reset is the OR of both active-low reset pins and system reset.
   wire rst = i_sys_rst || !pins.interface_reset_n || !pins.cpu_reset_n;

   logic mux_mode_q;
   always_ff @(posedge i_clk) begin
      if (rst) begin
         mux_mode_q <= pins.interface_select;
      end
   end

   wire lpc_on = !mux_mode_q && !rst;
   wire mux_on = mux_mode_q && !rst;

   // Block protection: pin low forces protection, otherwise the lock register decides.
   genvar b;
   generate
      for (b = 0; b < NUM_BLOCKS; b++) begin : g_prot
         if (b == TOP_BLOCK) begin : g_top
            assign o_block_protect[b] = !pins.top_lock_n || i_lock_reg[b];
         end else begin : g_main
            assign o_block_protect[b] = !pins.main_lock_n || i_lock_reg[b];
         end
      end
   endgenerate

   logic [4:0] aux_q;
   always_ff @(posedge i_clk) begin
      if (rst) begin
         aux_q <= '0;
      end else begin
         aux_q <= pins.aux_inputs;
      end
   end

   // LPC frame tracking.
   lpc_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic write_q, write_d;
   logic [31:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   logic [7:0] rdata_q;
   logic rd_pend_q;

   wire start_seen = !pins.frame_n && (pins.lad == LPC_START);
   wire [31:0] addr_next = {addr_q[27:0], pins.lad};
   wire [2:0] strap_addr = ~pins.chip_select_strap;
   wire id_match = (addr_next[ADDR_ID_MSB:ADDR_ID_LSB] == strap_addr);
   wire mem_space = addr_next[ADDR_MEM_BIT];
   wire cnt_last = (cnt_q == NIB_LAST);
   wire [2:0] cnt_inc = cnt_q + 3'h1;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      write_d = write_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      if (!pins.frame_n) begin
         cnt_d = '0;
         state_d = start_seen ? ST_CYC : ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               state_d = ST_IDLE;
            end
            ST_CYC: begin
               write_d = pins.lad[CYC_DIR_BIT];
               state_d = (pins.lad[3:2] == CYC_MEMORY) ? ST_ADDR : ST_IDLE;
            end
            ST_ADDR: begin
               addr_d = addr_next;
               cnt_d = cnt_inc;
               if (cnt_q == ADDR_LAST) begin
                  cnt_d = '0;
                  if (!id_match) begin
                     state_d = ST_IDLE;
                  end else begin
                     state_d = write_q ? ST_WDATA : ST_TAR_IN;
                  end
               end
            end
            ST_WDATA: begin
               wdata_d = {pins.lad, wdata_q[7:4]};
               cnt_d = cnt_last ? '0 : cnt_inc;
               if (cnt_last) begin
                  state_d = ST_TAR_IN;
               end
            end
            ST_TAR_IN: begin
               cnt_d = cnt_last ? '0 : cnt_inc;
               if (cnt_last) begin
                  state_d = ST_SYNC;
               end
            end
            ST_SYNC: begin
               state_d = write_q ? ST_TAR_OUT : ST_RDATA;
            end
            ST_RDATA: begin
               cnt_d = cnt_last ? '0 : cnt_inc;
               if (cnt_last) begin
                  state_d = ST_TAR_OUT;
               end
            end
            ST_TAR_OUT: begin
               cnt_d = cnt_last ? '0 : cnt_inc;
               if (cnt_last) begin
                  state_d = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!lpc_on) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         write_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         write_q <= write_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
      end
   end

   // Core requests. A write is issued once both data nibbles are in, so an abort
   // during the turnaround can no longer cancel it.
   wire lpc_enter_tar = (state_q != ST_TAR_IN) && (state_d == ST_TAR_IN) && pins.frame_n;
   wire lpc_mem_req = lpc_on && lpc_enter_tar && addr_d[ADDR_MEM_BIT];
   wire lpc_rd_req = lpc_mem_req && !write_d;
   wire lpc_wr_req = lpc_mem_req && write_d && write_allowed(wdata_d, i_pe_busy);

   // Programmer port.
   logic rc_q, g_n_q, w_n_q;
   logic [10:0] row_q;
   logic [7:0] col_q;
   logic [7:0] byte_out_q;
   logic byte_oe_n_q;
   logic mux_rd_pend_q;

   wire rc_fall = rc_q && !pins.row_col_select;
   wire rc_rise = !rc_q && pins.row_col_select;
   wire g_fall = g_n_q && !pins.read_enable_n;
   wire w_rise = !w_n_q && pins.write_strobe_n;
   wire mux_rd_req = mux_on && g_fall;
   wire mux_wr_req = mux_on && w_rise
      && write_allowed(pins.byte_lines, i_pe_busy);

   always_ff @(posedge i_clk) begin
      if (rst) begin
         rc_q <= 1'b1;
         g_n_q <= 1'b1;
         w_n_q <= 1'b1;
         row_q <= '0;
         col_q <= '0;
      end else begin
         rc_q <= pins.row_col_select;
         g_n_q <= pins.read_enable_n;
         w_n_q <= pins.write_strobe_n;
         if (mux_on && rc_fall) begin
            row_q <= pins.mux_addr_lines;
         end
         if (mux_on && rc_rise) begin
            col_q <= pins.mux_addr_lines[7:0];
         end
      end
   end

   // Core request register, shared by both ports; only one port is ever live.
   core_req_t req_q, req_d;
   always_comb begin
      req_d = '0;
      if (lpc_rd_req || lpc_wr_req) begin
         req_d = '{valid: 1'b1, we: lpc_wr_req, addr: addr_d[18:0], wdata: wdata_d};
      end else if (mux_rd_req || mux_wr_req) begin
         req_d = '{valid: 1'b1, we: mux_wr_req, addr: {col_q, row_q},
            wdata: pins.byte_lines};
      end
   end

   always_ff @(posedge i_clk) begin
      if (rst) begin
         req_q <= '0;
         rd_pend_q <= 1'b0;
         mux_rd_pend_q <= 1'b0;
         rdata_q <= '0;
         byte_out_q <= '0;
      end else begin
         req_q <= req_d;
         rd_pend_q <= req_q.valid && !req_q.we && lpc_on;
         mux_rd_pend_q <= req_q.valid && !req_q.we && mux_on;
         if (lpc_enter_tar && !write_d && !addr_d[ADDR_MEM_BIT]) begin
            rdata_q <= {3'h0, aux_q};
         end else if (rd_pend_q) begin
            rdata_q <= i_core_rdata;
         end
         if (mux_rd_pend_q) begin
            byte_out_q <= i_core_rdata;
         end
      end
   end

   // LPC drive: sync, read data low nibble first, then one cycle of all ones.
   logic [3:0] lad_d;
   logic lad_oe_n_d;
   always_comb begin
      lad_d = TAR_IDLE;
      lad_oe_n_d = 1'b1;
      if (lpc_on && pins.frame_n) begin
         unique case (state_d)
            ST_SYNC: begin
               lad_d = SYNC_READY;
               lad_oe_n_d = 1'b0;
            end
            ST_RDATA: begin
               lad_d = (cnt_d == '0) ? rdata_q[3:0] : rdata_q[7:4];
               lad_oe_n_d = 1'b0;
            end
            ST_TAR_OUT: begin
               lad_d = TAR_IDLE;
               lad_oe_n_d = (cnt_d != '0);
            end
            default: begin
               lad_d = TAR_IDLE;
               lad_oe_n_d = 1'b1;
            end
         endcase
      end
   end

   logic [3:0] lad_q;
   logic lad_oe_n_q;
   always_ff @(posedge i_clk) begin
      if (rst) begin
         lad_q <= TAR_IDLE;
         lad_oe_n_q <= 1'b1;
         byte_oe_n_q <= 1'b1;
      end else begin
         lad_q <= lad_d;
         lad_oe_n_q <= lad_oe_n_d;
         byte_oe_n_q <= !(mux_on && !pins.read_enable_n);
      end
   end

   assign o_lad = lad_q;
   assign o_lad_oe_n = lad_oe_n_q;
   assign o_byte_lines = byte_out_q;
   assign o_byte_lines_oe_n = byte_oe_n_q;
   assign o_ready_busy_n = !i_pe_busy;
   assign o_ready_busy_oe_n = !mux_on;
   assign o_core_req = req_q;
   assign o_cmd_reset = rst;
   assign o_mux_mode = mux_mode_q;
endmodule
`default_nettype wire

// ---- hw/flash_pins_pkg.sv ----
// Purpose: Shared constants and types for the flash host pin front end.
// Assumes: One 25 MHz clock, the LPC clock.
// Notes: Array core, command decoder and lock registers live outside.
`default_nettype none
package flash_pins_pkg;
   localparam logic [3:0] LPC_START = 4'h0;
   localparam logic [1:0] CYC_MEMORY = 2'h1;
   localparam int CYC_DIR_BIT = 1;
   localparam logic [3:0] SYNC_READY = 4'h0;
   localparam logic [3:0] TAR_IDLE = 4'hf;
   localparam logic [2:0] ADDR_LAST = 3'h7;
   localparam logic [2:0] NIB_LAST = 3'h1;
   localparam int ADDR_ID_LSB = 19;
   localparam int ADDR_ID_MSB = 21;
   localparam int ADDR_MEM_BIT = 22;
   localparam int NUM_BLOCKS = 8;
   localparam int TOP_BLOCK = 7;
   localparam logic [7:0] SUSPEND_CMD = 8'hb0;
   localparam int PIN_W = 40;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CYC, ST_ADDR, ST_WDATA, ST_TAR_IN, ST_SYNC, ST_RDATA, ST_TAR_OUT
   } lpc_state_t;

   // All asynchronous pins gathered so they can share one synchroniser bank.
   typedef struct packed {
      logic frame_n;
      logic [3:0] lad;
      logic [2:0] chip_select_strap;
      logic [4:0] aux_inputs;
      logic interface_select;
      logic interface_reset_n;
      logic cpu_reset_n;
      logic top_lock_n;
      logic main_lock_n;
      logic [10:0] mux_addr_lines;
      logic row_col_select;
      logic read_enable_n;
      logic write_strobe_n;
      logic [7:0] byte_lines;
   } pins_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [18:0] addr;
      logic [7:0] wdata;
   } core_req_t;
endpackage
`default_nettype wire

// ---- hw/pin_sync.sv ----
// Purpose: Two-flop synchroniser bank for pins arriving from outside.
// Assumes: Inputs are asynchronous to i_clk.
// Notes: Not reset, so reset pins themselves can pass through it.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk) begin
      meta_q <= i_async;
      sync_q <= meta_q;
   end

   assign o_sync = sync_q;
endmodule
`default_nettype wire
